/* core_model.sv */
/*
 Behavioural model of the CPU core interrupt sequencer at the far side of
 the enable bank. Assumes the bench tells it when a service routine ends.
*/
`timescale 1ns/1ps
module core_model (
	input  wire logic clock_i,
	input  wire logic arst_n_i,
	input  wire logic ret_req_i,
	output logic      return_from_irq_o
);
	// One-cycle return strobe on the CPU clock
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			return_from_irq_o <= 1'b0;
		end else begin
			return_from_irq_o <= ret_req_i & ~return_from_irq_o;
		end
	end
endmodule

/* irq_enable_pkg.sv */
/*
 Package for the peripheral interrupt enable bank: register offsets,
 implemented-bit masks, reset values, source indices and bus structs.
 Assumes a single 25 MHz CPU clock domain.
*/
package irq_enable_pkg;

	// Register byte addresses on the Avalon-MM bus
	localparam logic [9:0] OFFS_ENABLE_ONE = 10'h106;
	localparam logic [9:0] OFFS_ENABLE_TWO = 10'h108;
	localparam logic [9:0] OFFS_GROUP_CTRL = 10'h10c;
	localparam logic [9:0] OFFS_IRQ_STATUS = 10'h110;

	// Field positions, first enable register
	localparam int unsigned BIT_ADC_DONE   = 6;
	localparam int unsigned BIT_SERIAL_RX  = 5;
	localparam int unsigned BIT_SERIAL_TX  = 4;
	localparam int unsigned BIT_PWM_PERIOD = 2;
	localparam int unsigned BIT_T2_MATCH   = 1;
	localparam int unsigned BIT_T1_OVF     = 0;
	// Field positions, second enable register
	localparam int unsigned BIT_TOUCH_M1   = 7;
	localparam int unsigned BIT_TOUCH_M0   = 6;
	localparam int unsigned BIT_NVM_WRITE  = 4;
	localparam int unsigned BIT_PORTA_CHG  = 1;
	// Field positions, group control register
	localparam int unsigned BIT_GLOBAL_EN  = 7;
	localparam int unsigned BIT_GROUP_EN   = 6;

	// Implemented bits; all others read zero and drop writes
	localparam logic [7:0] MASK_ENABLE_ONE = 8'h77;
	localparam logic [7:0] MASK_ENABLE_TWO = 8'hd2;
	localparam logic [7:0] MASK_GROUP_CTRL = 8'hc0;

	// Reset values
	localparam logic [7:0] RESET_ENABLE    = 8'h00;
	localparam logic [7:0] RESET_GROUP     = 8'h00;

	// Bus answer timing: one wait cycle per access
	localparam int unsigned BUS_WAIT_CYCLES = 1;

	// Sixteen flag lanes: [7:0] first register, [15:8] second
	localparam int unsigned NUM_LANES = 16;

	typedef struct packed {
		logic       read;
		logic       write;
		logic [9:0] address;
		logic [31:0] writedata;
	} bus_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} bus_rsp_t;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_DONE
	} bus_state_t;

endpackage

/* irq_gate.sv */
/*
 Combinational gate of sixteen flag lanes against their enables and the
 two group-level enables. Assumes flags are levels held by peripherals.
*/
`timescale 1ns/1ps
module irq_gate (
	input  wire logic [15:0] flags_i,
	input  wire logic [15:0] enables_i,
	input  wire logic        group_en_i,
	input  wire logic        global_en_i,
	output logic      [15:0] pending_o,
	output logic             request_o
);

	// Per-lane AND; a generate keeps lanes uniform
	genvar lane;
	generate
		for (lane = 0; lane < irq_enable_pkg::NUM_LANES; lane++) begin : g_lane
			assign pending_o[lane] = flags_i[lane] & enables_i[lane];
		end
	endgenerate

	// Group and global enable gate the OR of all lanes
	assign request_o = (|pending_o) & group_en_i & global_en_i;

endmodule

/* peripheral_irq_enable_bank.sv */
/*
 Peripheral interrupt enable bank: two enable registers plus a group
 control register on an Avalon-MM slave with waitrequest, and the gate
 that forms the peripheral interrupt request to the CPU core.
 Assumes request flags arrive as levels on the CPU clock, and that the
 core pulses a return-from-interrupt strobe on the same clock.
*/
// How it works
// - Bit six of first enables ADC
// - Bit five of first enables serial receive
// - Bit four of first enables serial transmit
// - Bit two of first enables PWM period
// - Bit one of first enables timer2 match
// - First at 106H; bit zero timer1 overflow
// - Second at 108H; bits 5,3,2,0 unused
// - Bit seven of second enables touch M1
// - Bit six of second enables touch M0
// - Bit four of second enables EEPROM write
// - Bit one of second enables port A
// - Flags set regardless of any enable
// - Global enable gates all; reset clears, return sets
`timescale 1ns/1ps
module peripheral_irq_enable_bank (
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [9:0]  avs_address_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        adc_done_flag_i,
	input  wire logic        serial_rx_flag_i,
	input  wire logic        serial_tx_flag_i,
	input  wire logic        pulse_period_flag_i,
	input  wire logic        timer_two_match_flag_i,
	input  wire logic        timer_one_overflow_flag_i,
	input  wire logic        touch_m1_done_flag_i,
	input  wire logic        touch_m0_done_flag_i,
	input  wire logic        nvm_write_done_flag_i,
	input  wire logic        port_a_change_flag_i,
	input  wire logic        return_from_irq_i,
	output logic             periph_irq_o
);

	irq_enable_pkg::bus_req_t   req;
	irq_enable_pkg::bus_state_t state_reg;
	irq_enable_pkg::bus_state_t state_next;
	logic [7:0]  enable_one_reg;
	logic [7:0]  enable_two_reg;
	logic [7:0]  group_ctrl_reg;
	logic [31:0] readdata_reg;
	logic [31:0] readdata_next;
	logic [15:0] flags;
	logic [15:0] pending;
	logic        request;
	logic        request_reg;

	// Bundle bus inputs
	assign req = '{read: avs_read_i, write: avs_write_i,
		address: avs_address_i, writedata: avs_writedata_i};

	// Lane map; flags are passed straight through, never gated upstream
	assign flags[irq_enable_pkg::BIT_ADC_DONE]       = adc_done_flag_i;
	assign flags[irq_enable_pkg::BIT_SERIAL_RX]      = serial_rx_flag_i;
	assign flags[irq_enable_pkg::BIT_SERIAL_TX]      = serial_tx_flag_i;
	assign flags[irq_enable_pkg::BIT_PWM_PERIOD]     = pulse_period_flag_i;
	assign flags[irq_enable_pkg::BIT_T2_MATCH]       = timer_two_match_flag_i;
	assign flags[irq_enable_pkg::BIT_T1_OVF]         = timer_one_overflow_flag_i;
	assign flags[7]                                  = 1'b0;
	assign flags[3]                                  = 1'b0;
	assign flags[8 + irq_enable_pkg::BIT_TOUCH_M1]   = touch_m1_done_flag_i;
	assign flags[8 + irq_enable_pkg::BIT_TOUCH_M0]   = touch_m0_done_flag_i;
	assign flags[8 + irq_enable_pkg::BIT_NVM_WRITE]  = nvm_write_done_flag_i;
	assign flags[8 + irq_enable_pkg::BIT_PORTA_CHG]  = port_a_change_flag_i;
	assign flags[13]                                 = 1'b0;
	assign flags[11]                                 = 1'b0;
	assign flags[10]                                 = 1'b0;
	assign flags[8]                                  = 1'b0;

	// Address decode, used for both read and write
	function automatic logic hit(input logic [9:0] addr, input logic [9:0] offs);
		hit = (addr == offs);
	endfunction

	wire sel_one    = hit(req.address, irq_enable_pkg::OFFS_ENABLE_ONE);
	wire sel_two    = hit(req.address, irq_enable_pkg::OFFS_ENABLE_TWO);
	wire sel_group  = hit(req.address, irq_enable_pkg::OFFS_GROUP_CTRL);
	wire sel_status = hit(req.address, irq_enable_pkg::OFFS_IRQ_STATUS);
	wire lane0_on   = avs_byteenable_i[0];
	// Writes land in the single cycle where waitrequest is low
	wire accept     = (state_reg == irq_enable_pkg::BUS_DONE);
	wire wr_commit  = accept & req.write & lane0_on;

	// Unused positions masked so they drop writes and read zero
	wire [7:0] wdata_one   = req.writedata[7:0] & irq_enable_pkg::MASK_ENABLE_ONE;
	wire [7:0] wdata_two   = req.writedata[7:0] & irq_enable_pkg::MASK_ENABLE_TWO;
	wire [7:0] wdata_group = req.writedata[7:0] & irq_enable_pkg::MASK_GROUP_CTRL;

	// Return-from-interrupt sets global enable; a same-cycle write still lands, with global enable forced set
	wire [7:0] group_after_wr = (wr_commit && sel_group) ? wdata_group : group_ctrl_reg;
	wire [7:0] group_next = return_from_irq_i
		? (group_after_wr | (8'h01 << irq_enable_pkg::BIT_GLOBAL_EN)) : group_after_wr;

	// Read mux; unmapped addresses read zero
	always_comb begin
		readdata_next = 32'h0000_0000;
		if (sel_one)
			readdata_next = {24'h000000, enable_one_reg};
		else if (sel_two)
			readdata_next = {24'h000000, enable_two_reg};
		else if (sel_group)
			readdata_next = {24'h000000, group_ctrl_reg};
		else if (sel_status)
			readdata_next = {15'h0000, request_reg, pending};
	end

	// One wait cycle, then the answer with waitrequest low
	always_comb begin
		case (state_reg)
			irq_enable_pkg::BUS_IDLE: state_next = (req.read | req.write)
				? irq_enable_pkg::BUS_DONE : irq_enable_pkg::BUS_IDLE;
			irq_enable_pkg::BUS_DONE: state_next = irq_enable_pkg::BUS_IDLE;
			default:                  state_next = irq_enable_pkg::BUS_IDLE;
		endcase
	end

	assign avs_waitrequest_o = (req.read | req.write) & ~accept;
	assign avs_readdata_o    = readdata_reg;

	// Bus state and read data register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg    <= irq_enable_pkg::BUS_IDLE;
			readdata_reg <= 32'h0000_0000;
		end else begin
			state_reg    <= state_next;
			readdata_reg <= (state_reg == irq_enable_pkg::BUS_IDLE && req.read) ? readdata_next : readdata_reg;
		end
	end

	// Enable registers: reset to zero
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			enable_one_reg <= irq_enable_pkg::RESET_ENABLE;
			enable_two_reg <= irq_enable_pkg::RESET_ENABLE;
			group_ctrl_reg <= irq_enable_pkg::RESET_GROUP;
		end else begin
			if (wr_commit && sel_one)
				enable_one_reg <= wdata_one;
			if (wr_commit && sel_two)
				enable_two_reg <= wdata_two;
			group_ctrl_reg <= group_next;
		end
	end

	wire group_en  = group_ctrl_reg[irq_enable_pkg::BIT_GROUP_EN];
	wire global_en = group_ctrl_reg[irq_enable_pkg::BIT_GLOBAL_EN];

	irq_gate u_gate (
		.flags_i     (flags),
		.enables_i   ({enable_two_reg, enable_one_reg}),
		.group_en_i  (group_en),
		.global_en_i (global_en),
		.pending_o   (pending),
		.request_o   (request)
	);

	// Request registered so the core sees a clean level
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i)
			request_reg <= 1'b0;
		else
			request_reg <= request;
	end

	assign periph_irq_o = request_reg;

	// Assertions
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	a_group_gate_off: assert property (!group_en |=> !periph_irq_o)
		else $error("request while group enable low");
	a_adc_lane: assert property ((adc_done_flag_i && enable_one_reg[6] && group_en && global_en) |=> periph_irq_o)
		else $error("adc lane did not raise request");
	a_rx_lane_mask: assert property ((!enable_one_reg[5] |-> !pending[5]))
		else $error("rx lane pending while disabled");
	a_tx_lane: assert property ((serial_tx_flag_i && enable_one_reg[4]) |-> pending[4])
		else $error("tx lane not pending");
	a_pwm_lane: assert property (pending[2] == (pulse_period_flag_i && enable_one_reg[2]))
		else $error("pwm lane mismatch");
	a_t2_lane: assert property (pending[1] == (timer_two_match_flag_i && enable_one_reg[1]))
		else $error("timer2 lane mismatch");
	a_unused_one: assert property ((enable_one_reg & 8'h88) == 8'h00)
		else $error("unused bit set in first register");
	a_unused_two: assert property ((enable_two_reg & 8'h2d) == 8'h00)
		else $error("unused bit set in second register");
	a_touch_lanes: assert property (pending[15:14] == ({touch_m1_done_flag_i, touch_m0_done_flag_i} & enable_two_reg[7:6]))
		else $error("touch lanes mismatch");
	a_nvm_porta: assert property ({pending[12], pending[9]} == ({nvm_write_done_flag_i, port_a_change_flag_i} & {enable_two_reg[4], enable_two_reg[1]}))
		else $error("nvm or port a lane mismatch");
	a_global_gate: assert property (!global_en |=> !periph_irq_o)
		else $error("request while global enable low");
	a_rfi_sets_gie: assert property (return_from_irq_i |=> global_en)
		else $error("return did not set global enable");
	a_request_or: assert property (periph_irq_o == $past(|pending && group_en && global_en))
		else $error("request not the gated or");
	a_wr_one_lands: assert property ((wr_commit && sel_one) |=> enable_one_reg == $past(wdata_one))
		else $error("first register write lost");
	a_wait_one: assert property ((req.read && state_reg == irq_enable_pkg::BUS_IDLE) |=> !avs_waitrequest_o)
		else $error("bus answer late");

	c_irq_raised: cover property (!periph_irq_o ##1 periph_irq_o);
	c_write_one: cover property (wr_commit && sel_one);
	c_rfi: cover property (return_from_irq_i && !global_en);
	c_unmapped_read: cover property (accept && req.read && !sel_one && !sel_two && !sel_group && !sel_status);

endmodule

/* test_peripheral_irq_enable_bank.sv */
/*
 Self-checking bench for the peripheral interrupt enable bank.
 Assumes the core model above and one 25 MHz clock.
*/
`timescale 1ns/1ps
module test_peripheral_irq_enable_bank;
	logic        clock_i, arst_n_i, avs_read_i, avs_write_i, ret_req, ret_pulse, periph_irq_o;
	logic        avs_waitrequest_o;
	logic [9:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic [3:0]  avs_byteenable_i;
	logic [15:0] lanes;
	int          checked, mismatches;
	int          lane_tab [10] = '{6, 5, 4, 2, 1, 0, 15, 14, 12, 9};

	// Flag lanes: [7:0] first register positions, [15:8] second
	peripheral_irq_enable_bank u_peripheral_irq_enable_bank (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_address_i(avs_address_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.adc_done_flag_i(lanes[6]), .serial_rx_flag_i(lanes[5]), .serial_tx_flag_i(lanes[4]),
		.pulse_period_flag_i(lanes[2]), .timer_two_match_flag_i(lanes[1]),
		.timer_one_overflow_flag_i(lanes[0]), .touch_m1_done_flag_i(lanes[15]),
		.touch_m0_done_flag_i(lanes[14]), .nvm_write_done_flag_i(lanes[12]),
		.port_a_change_flag_i(lanes[9]), .return_from_irq_i(ret_pulse), .periph_irq_o(periph_irq_o));
	core_model u_core_model (.clock_i(clock_i), .arst_n_i(arst_n_i), .ret_req_i(ret_req),
		.return_from_irq_o(ret_pulse));

	// Clock
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end

	task automatic check(input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic check_irq(input logic e);
		checked++;
		if (periph_irq_o !== e) begin
			mismatches++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, periph_irq_o);
		end
	endtask

	// Held until waitrequest is seen low; idle edge after, no same-step re-drive
	// Waitrequest and read data looked at mid-cycle: settled, and equal to what the next rising edge samples
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
		int   n;
		logic seen;
		n = 0;
		seen = 1'b1;
		avs_read_i <= ~w;
		avs_write_i <= w;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= be;
		do begin
			@(negedge clock_i);
			seen = avs_waitrequest_o;
			rd = avs_readdata_o;
			@(posedge clock_i);
			n++;
		end while (seen !== 1'b0 && n < 50);
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (seen !== 1'b0) check(32'h0, 32'h1);
		@(posedge clock_i);
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask

	task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'h0);
		check(e, rd);
	endtask

	task automatic t_regs;
		rd_chk(10'h106, 32'h0);
		rd_chk(10'h108, 32'h0);
		wr(10'h106, 32'hffff_ffff);
		rd_chk(10'h106, 32'h77);
		wr(10'h108, 32'hffff_ffff);
		rd_chk(10'h108, 32'hd2);
		bus(1'b1, 10'h106, 32'h0, 4'h0);
		rd_chk(10'h106, 32'h77);
		rd_chk(10'h104, 32'h0);
		$display("test regs done");
	endtask

	// Each lane alone must raise the request, and its own enable must drop it
	task automatic t_lanes;
		int l;
		wr(10'h10c, 32'hc0);
		foreach (lane_tab[i]) begin
			l = lane_tab[i];
			lanes <= 16'h1 << l;
			wr(10'h106, 32'hff);
			wr(10'h108, 32'hff);
			repeat (2) @(posedge clock_i);
			check_irq(1'b1);
			rd_chk(10'h110, 32'h1_0000 | (32'h1 << l));
			if (l < 8) wr(10'h106, ~(32'h1 << l));
			else wr(10'h108, ~(32'h1 << (l - 8)));
			repeat (2) @(posedge clock_i);
			check_irq(1'b0);
		end
		$display("test lanes done");
	endtask

	task automatic t_gate;
		lanes <= 16'h0040;
		wr(10'h106, 32'h40);
		wr(10'h10c, 32'h40);
		repeat (2) @(posedge clock_i);
		check_irq(1'b0);
		rd_chk(10'h110, 32'h40);
		wr(10'h10c, 32'h80);
		repeat (2) @(posedge clock_i);
		check_irq(1'b0);
		wr(10'h10c, 32'h40);
		ret_req <= 1'b1;
		@(posedge clock_i);
		ret_req <= 1'b0;
		repeat (3) @(posedge clock_i);
		check_irq(1'b1);
		rd_chk(10'h10c, 32'hc0);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		check_irq(1'b0);
		rd_chk(10'h10c, 32'h0);
		rd_chk(10'h106, 32'h0);
		$display("test gate done");
	endtask

	task automatic close_out;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{arst_n_i, avs_read_i, avs_write_i, ret_req} = 4'h0;
		avs_address_i = 10'h0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'h0;
		lanes = 16'h0;
		repeat (5) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		t_regs();
		t_lanes();
		t_gate();
		close_out();
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#(40 * 20000);
		mismatches++;
		close_out();
	end
endmodule
